/* File: design/acpt_top.sv */
// Trigger control for the converter input pairs, with APB registers and interrupt.
// Assumes trigger inputs are one-cycle pulses on mclk and a converter that takes
// one pair request at a time and reports completion with the pair number.
//
// The placing of the registers and the APB interface to the registers were decided locally.
module acpt_top
   import acpt_pkg::*;
#(
   parameter int PAIRS = NUM_PAIRS
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trig_special,
   input wire logic [7:0] trig_pwm_pri,
   input wire logic tmr1_match,
   input wire logic trig_sec_special,
   input wire logic [8:0] trig_pwm_sec,
   input wire logic [7:0] trig_pwm_cl,
   input wire logic tmr2_match,
   input wire logic conv_free,
   input wire logic conv_done,
   input wire logic [2:0] conv_done_pair,
   output logic conv_start,
   output logic [2:0] conv_pair,
   output logic [4:0] conv_input_hi,
   output logic [4:0] conv_input_lo,
   output logic irq
);

   logic [PAIRS-1:0] irqen_reg;
   logic [PAIRS-1:0] pend_reg;
   logic [PAIRS-1:0] swtrg_reg;
   logic [PAIRS-1:0] issued_reg;
   logic [SRC_W-1:0] src_reg [PAIRS];
   logic [PAIRS-1:0] istat_reg;
   logic [PAIRS-1:0] ien_reg;
   logic gtrig_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic conv_start_reg;
   logic [2:0] conv_pair_reg;
   logic [4:0] conv_hi_reg;
   logic [4:0] conv_lo_reg;
   logic irq_reg;
   logic wr_en;
   logic [PAIRS-1:0] trig_hit;
   logic [PAIRS-1:0] done_hit;
   logic [PAIRS-1:0] pend_set;
   logic [PAIRS-1:0] waiting;
   logic pick_valid;
   logic [2:0] pick;

   // Selected trigger of one pair; code 0 and unknown codes select nothing
   function automatic logic sel_trigger(
      input logic [SRC_W-1:0] src,
      input logic sw,
      input logic gl
   );
      logic hit;
      hit = 1'b0;
      if (src == SRC_SOFT) begin
         hit = sw;
      end else if (src == SRC_GLOBAL) begin
         hit = sw | gl;
      end else if (src == SRC_SPECIAL) begin
         hit = trig_special;
      end else if (src >= SRC_PRI_FIRST && src <= SRC_PRI_LAST) begin
         hit = trig_pwm_pri[3'(src - SRC_PRI_FIRST)];
      end else if (src == SRC_TMR1) begin
         hit = tmr1_match;
      end else if (src == SRC_SEC_SPECIAL) begin
         hit = trig_sec_special;
      end else if (src >= SRC_SEC_FIRST && src <= SRC_SEC_LAST) begin
         hit = trig_pwm_sec[4'(src - SRC_SEC_FIRST)];
      end else if (src >= SRC_CL_FIRST && src <= SRC_CL_LAST) begin
         hit = trig_pwm_cl[3'(src - SRC_CL_FIRST)];
      end else if (src == SRC_TMR2) begin
         hit = tmr2_match;
      end
      return hit;
   endfunction

   // Byte image of one pair, enable/pending/soft trigger/source
   function automatic logic [7:0] pair_byte(input int p);
      logic [7:0] b;
      b = 8'h00;
      if (p < PAIRS) begin
         b[IRQEN_BIT] = irqen_reg[p];
         b[PEND_BIT] = pend_reg[p];
         b[SWTRG_BIT] = swtrg_reg[p];
         b[SRC_LSB +: SRC_W] = src_reg[p];
      end
      return b;
   endfunction

   // Register offset that holds a pair's byte
   function automatic logic [7:0] pair_ofs(input int p);
      logic [7:0] o;
      o = OFS_CTRL0;
      if ((p >> 1) == 1) begin
         o = OFS_CTRL1;
      end else if ((p >> 1) == 2) begin
         o = OFS_CTRL2;
      end
      return o;
   endfunction

   // Lane write decode, taken only at the access edge
   function automatic logic lane_write(input logic [7:0] ofs, input int lane);
      return wr_en && paddr == ofs && pstrb[lane];
   endfunction

   // Addresses that answer without an error
   function automatic logic addr_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         OFS_CTRL0, OFS_CTRL1, OFS_CTRL2, OFS_GTRIG: hit = 1'b1;
         OFS_ISTAT, OFS_IEN, OFS_ICLR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   assign wr_en = psel & penable & pwrite & pready_reg;

   always_comb begin
      for (int p = 0; p < PAIRS; p++) begin
         trig_hit[p] = (src_reg[p] != SRC_OFF) && sel_trigger(src_reg[p], swtrg_reg[p], gtrig_reg);
         done_hit[p] = conv_done && (conv_done_pair == 3'(p));
         pend_set[p] = trig_hit[p];
         waiting[p] = pend_reg[p] & ~issued_reg[p];
      end
   end

   // Fixed priority, lowest pair first
   always_comb begin
      pick_valid = 1'b0;
      pick = 3'h0;
      for (int p = PAIRS - 1; p >= 0; p--) begin
         if (waiting[p]) begin
            pick_valid = 1'b1;
            pick = 3'(p);
         end
      end
   end

   // Interrupt enable bits: odd pair in high byte, even pair in low byte
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irqen_reg <= '0;
      end else begin
         for (int p = 0; p < PAIRS; p++) begin
            if (lane_write(pair_ofs(p), p % 2)) begin
               irqen_reg[p] <= pwdata[8 * (p % 2) + IRQEN_BIT];
            end
         end
      end
   end

   // Trigger source fields, same byte placement
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int p = 0; p < PAIRS; p++) begin
            src_reg[p] <= SRC_RESET;
         end
      end else begin
         for (int p = 0; p < PAIRS; p++) begin
            if (lane_write(pair_ofs(p), p % 2)) begin
               src_reg[p] <= pwdata[8 * (p % 2) + SRC_LSB +: SRC_W];
            end
         end
      end
   end

   // Software trigger bits; the hardware clear beats a same-cycle write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         swtrg_reg <= '0;
      end else begin
         for (int p = 0; p < PAIRS; p++) begin
            if (pend_set[p]) begin
               swtrg_reg[p] <= 1'b0;
            end else if (lane_write(pair_ofs(p), p % 2)) begin
               swtrg_reg[p] <= pwdata[8 * (p % 2) + SWTRG_BIT];
            end
         end
      end
   end

   // Pending and issue tracking; a new trigger wins over a same-cycle completion
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pend_reg <= '0;
         issued_reg <= '0;
      end else begin
         for (int p = 0; p < PAIRS; p++) begin
            if (pend_set[p]) begin
               pend_reg[p] <= 1'b1;
            end else if (done_hit[p]) begin
               pend_reg[p] <= 1'b0;
            end
            if (done_hit[p] || pend_set[p]) begin
               issued_reg[p] <= 1'b0;
            end else if (conv_start_reg && conv_pair_reg == 3'(p)) begin
               issued_reg[p] <= 1'b1;
            end
         end
      end
   end

   // Global software trigger: write pulse lasting one cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         gtrig_reg <= 1'b0;
      end else begin
         gtrig_reg <= lane_write(OFS_GTRIG, 0) && pwdata[GTRIG_BIT];
      end
   end

   // Converter request: held back while the converter is busy
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         conv_start_reg <= 1'b0;
         conv_pair_reg <= 3'h0;
         conv_hi_reg <= 5'h01;
         conv_lo_reg <= 5'h00;
      end else begin
         conv_start_reg <= 1'b0;
         if (pick_valid && conv_free && !conv_start_reg) begin
            conv_start_reg <= 1'b1;
            conv_pair_reg <= pick;
            conv_hi_reg <= 5'({pick, 1'b1});
            conv_lo_reg <= 5'({pick, 1'b0});
         end
      end
   end

   // Sticky completion status; set wins over a same-cycle clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         istat_reg <= '0;
      end else begin
         for (int p = 0; p < PAIRS; p++) begin
            if (done_hit[p] && irqen_reg[p]) begin
               istat_reg[p] <= 1'b1;
            end else if (lane_write(OFS_ICLR, 0) && pwdata[p]) begin
               istat_reg[p] <= 1'b0;
            end
         end
      end
   end

   // Interrupt enable register, same layout as the status
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ien_reg <= '0;
      end else if (lane_write(OFS_IEN, 0)) begin
         ien_reg <= pwdata[PAIRS-1:0];
      end
   end

   // Level interrupt, one cycle behind the status it reports
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(istat_reg & ien_reg);
      end
   end

   // APB answer: zero wait states
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= psel & ~penable;
      end
   end

   // Error on an unmapped address, flagged with the ready cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= psel && !penable && !addr_mapped(paddr);
      end
   end

   // Read data latched at the setup edge, so status reads are a snapshot
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            OFS_CTRL0: prdata_reg <= {16'h0000, pair_byte(1), pair_byte(0)};
            OFS_CTRL1: prdata_reg <= {16'h0000, pair_byte(3), pair_byte(2)};
            OFS_CTRL2: prdata_reg <= {16'h0000, pair_byte(5), pair_byte(4)};
            OFS_GTRIG: prdata_reg <= 32'h0000_0000;
            OFS_ISTAT: prdata_reg <= 32'(istat_reg);
            OFS_IEN: prdata_reg <= 32'(ien_reg);
            OFS_ICLR: prdata_reg <= 32'h0000_0000;
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign conv_start = conv_start_reg;
   assign conv_pair = conv_pair_reg;
   assign conv_input_hi = conv_hi_reg;
   assign conv_input_lo = conv_lo_reg;
   assign irq = irq_reg;

endmodule // acpt_top

/* File: inc/acpt_pkg.sv */
// Constants for the converter pair trigger control block.
// Assumes a 32-bit APB slave port, one aligned word per register.
package acpt_pkg;
   localparam int NUM_PAIRS = 6;
   localparam int SRC_W = 5;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL2 = 8'h08;
   localparam logic [7:0] OFS_GTRIG = 8'h0C;
   localparam logic [7:0] OFS_ISTAT = 8'h10;
   localparam logic [7:0] OFS_IEN = 8'h14;
   localparam logic [7:0] OFS_ICLR = 8'h18;
   // Field positions inside one pair byte and the global trigger word, then reset values
   localparam int IRQEN_BIT = 7;
   localparam int PEND_BIT = 6;
   localparam int SWTRG_BIT = 5;
   localparam int SRC_LSB = 0;
   localparam int GTRIG_BIT = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [SRC_W-1:0] SRC_RESET = 5'h00;
   // Trigger source encodings
   localparam logic [SRC_W-1:0] SRC_OFF = 5'h00;
   localparam logic [SRC_W-1:0] SRC_SOFT = 5'h01;
   localparam logic [SRC_W-1:0] SRC_GLOBAL = 5'h02;
   localparam logic [SRC_W-1:0] SRC_SPECIAL = 5'h03;
   localparam logic [SRC_W-1:0] SRC_PRI_FIRST = 5'h04;
   localparam logic [SRC_W-1:0] SRC_PRI_LAST = 5'h0B;
   localparam logic [SRC_W-1:0] SRC_TMR1 = 5'h0C;
   localparam logic [SRC_W-1:0] SRC_SEC_SPECIAL = 5'h0D;
   localparam logic [SRC_W-1:0] SRC_SEC_FIRST = 5'h0E;
   localparam logic [SRC_W-1:0] SRC_SEC_LAST = 5'h16;
   localparam logic [SRC_W-1:0] SRC_CL_FIRST = 5'h17;
   localparam logic [SRC_W-1:0] SRC_CL_LAST = 5'h1E;
   localparam logic [SRC_W-1:0] SRC_TMR2 = 5'h1F;
endpackage : acpt_pkg

/* File: bench/acpt_checker.sv */
// Assertions on the pins of the pair trigger control block.
// Assumes the top module acpt_top; attached by the bind at the foot.
module acpt_checker (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_free,
   input wire logic conv_start,
   input wire logic [2:0] conv_pair,
   input wire logic [4:0] conv_input_hi,
   input wire logic [4:0] conv_input_lo,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence write_done_s;
      psel && penable && pwrite;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_unmapped_a: assert property (setup_s ##0 paddr > 8'h18 |=> pslverr && pready)
      else $error("unmapped access not refused");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error response carries data");
   start_gap_a: assert property (conv_start |=> !conv_start)
      else $error("conversion starts back to back");
   start_free_a: assert property (conv_start |-> $past(conv_free))
      else $error("start while converter busy");
   pair_inputs_a: assert property (conv_input_lo == {1'b0, conv_pair, 1'b0} && conv_input_hi == {1'b0, conv_pair, 1'b1})
      else $error("inputs do not match pair");
   pair_hold_a: assert property ($changed(conv_pair) |-> conv_start)
      else $error("pair changed without start");
   irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2))
      else $error("interrupt dropped without a write");
   write_ready_a: assert property (write_done_s |-> pready)
      else $error("write access without ready");
endmodule // acpt_checker

bind acpt_top acpt_checker i_acpt_checker (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .conv_free, .conv_start, .conv_pair, .conv_input_hi, .conv_input_lo, .irq);

/* File: bench/acpt_top_test.sv */
// Self-checking bench for the pair trigger control block.
// Assumes acpt_pkg and acpt_top compiled first; bench acts as APB master and converter.
module acpt_top_test;
   import acpt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_free = 1'b0, conv_done = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [2:0] conv_done_pair = 3'h0;
   // Trigger inputs in source-code order, bit = code minus 3
   logic [28:0] trg = 29'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, conv_start, irq;
   logic [2:0] conv_pair;
   logic [4:0] conv_input_hi, conv_input_lo;
   logic [32:0] rq[$];
   logic [32:0] cq[$];
   int fail_count = 0, check_count = 0, cyc = 0;

   acpt_top i_acpt_top (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .trig_special(trg[0]), .trig_pwm_pri(trg[8:1]), .tmr1_match(trg[9]),
      .trig_sec_special(trg[10]), .trig_pwm_sec(trg[19:11]), .trig_pwm_cl(trg[27:20]), .tmr2_match(trg[28]),
      .conv_free, .conv_done, .conv_done_pair, .conv_start, .conv_pair, .conv_input_hi, .conv_input_lo, .irq);

   initial forever #4 mclk = ~mclk;

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Result watcher and hang guard
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, rq.pop_front());
      if (conv_start === 1'b1) check({conv_pair, conv_input_hi, conv_input_lo}, cq.pop_front());
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      int p;
      int c;
      logic [31:0] v;
      v = $urandom(32'h58ed_b7fa);
      tick(16);
      rstn <= 1'b1;
      for (p = 0; p < 8; p++) if (p != 3) rd(8'(4 * p), {p == 7, 32'h0000_0000});
      apb(1'b1, OFS_ISTAT, 32'hFFFF_FFFF);
      rd(OFS_ISTAT, 33'h0);
      $display("test reset done");
      apb(1'b1, OFS_IEN, 32'h0000_003F);
      for (p = 0; p < 6; p++) begin
         cq.push_back({p[2:0], 5'(2 * p + 1), 5'(2 * p)});
         apb(1'b1, 8'(4 * (p / 2)), 32'h0000_00A1 << (8 * (p % 2)), 4'b0001 << (p % 2));
         tick(3);
         rd(8'(4 * (p / 2)), (p % 2) ? 33'h0000_C181 : 33'h0000_00C1);
         conv_free <= 1'b1;
         for (c = 0; c < 20 && conv_start !== 1'b1; c++) @(posedge mclk);
         conv_free <= 1'b0;
         conv_done_pair <= 3'(p);
         conv_done <= 1'b1;
         @(posedge mclk);
         conv_done <= 1'b0;
         tick(2);
         check(irq, 33'h1);
         rd(OFS_ISTAT, 33'(1 << p));
         apb(1'b1, OFS_IEN, 32'h0000_0000);
         tick(2);
         check(irq, 33'h0);
         apb(1'b1, OFS_IEN, 32'h0000_003F);
         tick(2);
         check(irq, 33'h1);
         apb(1'b1, OFS_ICLR, 32'(1 << p));
         tick(2);
         check(irq, 33'h0);
         rd(8'(4 * (p / 2)), (p % 2) ? 33'h0000_8181 : 33'h0000_0081);
      end
      $display("test soft trigger done");
      // Pair 4 walks every source code with the converter held busy
      for (c = 0; c < 32; c++) begin
         apb(1'b1, OFS_CTRL2, 32'(c), 4'b0001);
         @(posedge mclk);
         trg <= 29'($urandom) & ~((c >= 3) ? 29'h1 << (c - 3) : 29'h0);
         @(posedge mclk);
         trg <= 29'h0;
         tick(2);
         rd(OFS_CTRL2, 33'h0000_8100 | 33'(c));
         if (c == 2) apb(1'b1, OFS_GTRIG, 32'h0000_0001);
         if (c >= 3) begin
            @(posedge mclk);
            trg <= 29'h1 << (c - 3);
            @(posedge mclk);
            trg <= 29'h0;
         end
         tick(2);
         rd(OFS_CTRL2, 33'h0000_8100 | 33'(c) | ((c >= 2) ? 33'h40 : 33'h0));
         conv_done_pair <= 3'd4;
         conv_done <= 1'b1;
         @(posedge mclk);
         conv_done <= 1'b0;
         tick(2);
      end
      // Global source first, then the pair's own trigger bit
      apb(1'b1, OFS_CTRL2, 32'h0000_0002, 4'b0001);
      apb(1'b1, OFS_CTRL2, 32'h0000_0022, 4'b0001);
      tick(2);
      rd(OFS_CTRL2, 33'h0000_8142);
      conv_done_pair <= 3'd4;
      conv_done <= 1'b1;
      @(posedge mclk);
      conv_done <= 1'b0;
      tick(2);
      rd(OFS_CTRL2, 33'h0000_8102);
      check(irq, 33'h0);
      $display("test sources done");
      give_verdict();
   end
endmodule // acpt_top_test
